// ===== src/dfa_top.sv
// Drive fault annunciator: fault latch, lamp patterns, display text, restart control
//
// Overview of operation
// - Healthy run shows steady green only.
// - Each fault shown on three coloured lamps.
// - Keypad units also show fault text.
// - Power cycle clears any fault; off key clears restartable ones, keypad units only.
// - Power loss erases stored fault indication.
// - No keypad means no self restart.
// - Pending restart shows countdown of seconds.
// - Per-fault restart count and delay, default none.
// - Output short flashes green, red; power only.
// - Over temperature steady yellow; may auto restart.
// - Bus overvoltage flashes green, yellow; power only.
// - Undercurrent flashes yellow; may auto restart.
// - Single phasing steady yellow, green; power only.
// - Internal short steady green, flash red.
// - Low input flash red, steady yellow; restartable.
// - Output overcurrent flashes all lamps; restartable.
// - Defective fan steady red; power only.
// - Power-only faults keep drive off until cycled.
`default_nettype none
module dfa_top #(
    parameter int HALF_SEC_CYCLES = dfa_pkg::HALF_SEC_CYC
) (
    input  wire logic                            clock,
    input  wire logic                            arst_n,
    input  wire logic [dfa_pkg::NUM_FAULTS-1:0]  fault_hit,
    input  wire logic                            keypad_strap,
    input  wire logic                            off_key,
    input  wire logic                            cfg_wr,
    input  wire logic [dfa_pkg::SLOT_W-1:0]      cfg_slot,
    input  wire logic [dfa_pkg::CNT_W-1:0]       cfg_count,
    input  wire logic [dfa_pkg::SEC_W-1:0]       cfg_delay,
    input  wire logic                            disp_row,
    input  wire logic [dfa_pkg::COL_W-1:0]       disp_col,
    output logic      [7:0]                      disp_char,
    output logic                                 lamp_green,
    output logic                                 lamp_yellow,
    output logic                                 lamp_red,
    output logic                                 drive_run,
    output logic                                 restart_pending,
    output logic      [3:0]                      fault_code,
    output logic                                 keypad_fitted
);
    typedef struct packed {
        dfa_pkg::dfa_state_e                                 state;
        dfa_pkg::dfa_fault_e                                 code;
        logic [dfa_pkg::SEC_W-1:0]                           secs;
        logic [dfa_pkg::TICK_W-1:0]                          tick;
        logic                                                second_half;
        logic                                                flash;
        logic [dfa_pkg::NUM_FAULTS-1:0]                      hit_s1;
        logic [dfa_pkg::NUM_FAULTS-1:0]                      hit_s2;
        logic                                                key_s1;
        logic                                                key_s2;
        logic                                                key_s3;
        logic                                                strap_s1;
        logic                                                strap_s2;
        logic [1:0]                                          init_cnt;
        logic                                                fitted;
        logic [dfa_pkg::NUM_AUTO-1:0][dfa_pkg::CNT_W-1:0]    cfg_cnt;
        logic [dfa_pkg::NUM_AUTO-1:0][dfa_pkg::CNT_W-1:0]    rem;
        logic [dfa_pkg::NUM_AUTO-1:0][dfa_pkg::SEC_W-1:0]    cfg_dly;
        logic [7:0]                                          chr;
    } dfa_core_s;

    // Power-on state: healthy, no restarts programmed
    localparam dfa_core_s RESET_S = '{
        state   : dfa_pkg::ST_NORMAL,
        code    : dfa_pkg::F_NONE,
        chr     : dfa_pkg::CHR_SPACE,
        default : '0
    };

    dfa_core_s s_reg;
    dfa_core_s s_next;

    // Faults that only a power cycle may clear
    function automatic logic power_only(input dfa_pkg::dfa_fault_e f);
        unique case (f)
            dfa_pkg::F_OUTPUT_SHORT,
            dfa_pkg::F_BUS_OVERVOLT,
            dfa_pkg::F_SINGLE_PHASING,
            dfa_pkg::F_INTERNAL_SHORT,
            dfa_pkg::F_DEFECTIVE_FAN:   power_only = 1'b1;
            default:                    power_only = 1'b0;
        endcase
    endfunction : power_only

    // Restart slot of each restartable fault
    function automatic logic [dfa_pkg::SLOT_W-1:0] slot_of(input dfa_pkg::dfa_fault_e f);
        unique case (f)
            dfa_pkg::F_OVER_TEMP:       slot_of = 2'h0;
            dfa_pkg::F_UNDER_CURRENT:   slot_of = 2'h1;
            dfa_pkg::F_LOW_INPUT_VOLT:  slot_of = 2'h2;
            dfa_pkg::F_OVERCURRENT_OUT: slot_of = 2'h3;
            default:                    slot_of = 2'h0;
        endcase
    endfunction : slot_of

    // Lamp pattern as {green, yellow, red}
    function automatic logic [5:0] lamp_pattern(input dfa_pkg::dfa_fault_e f);
        unique case (f)
            dfa_pkg::F_OUTPUT_SHORT:    lamp_pattern = {dfa_pkg::LAMP_FLASH,
                dfa_pkg::LAMP_OFF, dfa_pkg::LAMP_FLASH};
            dfa_pkg::F_OVER_TEMP:       lamp_pattern = {dfa_pkg::LAMP_OFF,
                dfa_pkg::LAMP_ON, dfa_pkg::LAMP_OFF};
            dfa_pkg::F_BUS_OVERVOLT:    lamp_pattern = {dfa_pkg::LAMP_FLASH,
                dfa_pkg::LAMP_FLASH, dfa_pkg::LAMP_OFF};
            dfa_pkg::F_UNDER_CURRENT:   lamp_pattern = {dfa_pkg::LAMP_OFF,
                dfa_pkg::LAMP_FLASH, dfa_pkg::LAMP_OFF};
            dfa_pkg::F_SINGLE_PHASING:  lamp_pattern = {dfa_pkg::LAMP_ON,
                dfa_pkg::LAMP_ON, dfa_pkg::LAMP_OFF};
            dfa_pkg::F_INTERNAL_SHORT:  lamp_pattern = {dfa_pkg::LAMP_ON,
                dfa_pkg::LAMP_OFF, dfa_pkg::LAMP_FLASH};
            dfa_pkg::F_LOW_INPUT_VOLT:  lamp_pattern = {dfa_pkg::LAMP_OFF,
                dfa_pkg::LAMP_ON, dfa_pkg::LAMP_FLASH};
            dfa_pkg::F_OVERCURRENT_OUT: lamp_pattern = {dfa_pkg::LAMP_FLASH,
                dfa_pkg::LAMP_FLASH, dfa_pkg::LAMP_FLASH};
            dfa_pkg::F_DEFECTIVE_FAN:   lamp_pattern = {dfa_pkg::LAMP_OFF,
                dfa_pkg::LAMP_OFF, dfa_pkg::LAMP_ON};
            default:                    lamp_pattern = {dfa_pkg::LAMP_ON,
                dfa_pkg::LAMP_OFF, dfa_pkg::LAMP_OFF};
        endcase
    endfunction : lamp_pattern

    // Top row text for the latched fault
    function automatic logic [127:0] fault_text(input dfa_pkg::dfa_fault_e f);
        unique case (f)
            dfa_pkg::F_OUTPUT_SHORT:    fault_text = "OUTPUT FAULT    ";
            dfa_pkg::F_OVER_TEMP:       fault_text = "OVER TEMP       ";
            dfa_pkg::F_BUS_OVERVOLT:    fault_text = "BUS OVERVOLTAGE ";
            dfa_pkg::F_UNDER_CURRENT:   fault_text = "UNDER CURRENT   ";
            dfa_pkg::F_SINGLE_PHASING:  fault_text = "SINGLE PHASING  ";
            dfa_pkg::F_INTERNAL_SHORT:  fault_text = "INTERNAL SHORT  ";
            dfa_pkg::F_LOW_INPUT_VOLT:  fault_text = "LOW INPUT VOLT  ";
            dfa_pkg::F_OVERCURRENT_OUT: fault_text = "OVERCURRENT OUT ";
            dfa_pkg::F_DEFECTIVE_FAN:   fault_text = "DEFECTIVE FAN   ";
            default:                    fault_text = "SYSTEM NORMAL   ";
        endcase
    endfunction : fault_text

    // Pick one character of a 16 character string, leftmost first
    function automatic logic [7:0] pick_char(input logic [127:0] s, input logic [3:0] col);
        pick_char = s[{~col, 3'b000} +: 8];
    endfunction : pick_char

    dfa_pkg::dfa_fault_e           first_hit;
    logic                          half_tick;
    logic                          sec_tick;
    logic                          key_press;
    logic [dfa_pkg::SLOT_W-1:0]    slot;
    logic [127:0]                  row_text;
    logic [7:0]                    d_hund;
    logic [7:0]                    d_ten;
    logic [7:0]                    d_one;
    logic [5:0]                    pattern;

    // Next-state logic for the whole annunciator
    always_comb begin
        s_next    = s_reg;
        first_hit = dfa_pkg::F_NONE;
        row_text  = '0;
        d_hund    = '0;
        d_ten     = '0;
        d_one     = '0;

        // Pin synchronisers
        s_next.hit_s1   = fault_hit;
        s_next.hit_s2   = s_reg.hit_s1;
        s_next.key_s1   = off_key;
        s_next.key_s2   = s_reg.key_s1;
        s_next.key_s3   = s_reg.key_s2;
        s_next.strap_s1 = keypad_strap;
        s_next.strap_s2 = s_reg.strap_s1;

        // Catch the keypad strap once after reset release
        if (s_reg.init_cnt != dfa_pkg::STRAP_DONE) begin
            s_next.init_cnt = s_reg.init_cnt + 2'h1;
            if (s_reg.init_cnt == dfa_pkg::STRAP_TAKE) begin
                s_next.fitted = s_reg.strap_s2;
            end
        end

        // Half-second timebase for flashing and countdown
        half_tick = (s_reg.tick == dfa_pkg::TICK_W'(HALF_SEC_CYCLES - 1));
        sec_tick  = half_tick && s_reg.second_half;
        if (half_tick) begin
            s_next.tick        = '0;
            s_next.flash       = ~s_reg.flash;
            s_next.second_half = ~s_reg.second_half;
        end else begin
            s_next.tick = s_reg.tick + dfa_pkg::TICK_W'(1);
        end

        // Off key counts only when a keypad is fitted
        key_press = s_reg.fitted && s_reg.key_s2 && !s_reg.key_s3;

        // Lowest numbered active detector wins
        for (int i = dfa_pkg::NUM_FAULTS - 1; i >= 0; i--) begin
            if (s_reg.hit_s2[i]) begin
                first_hit = dfa_pkg::dfa_fault_e'(4'(i));
            end
        end
        slot = slot_of(first_hit);

        // Restart settings per fault, written from the keypad side
        if (cfg_wr) begin
            s_next.cfg_cnt[cfg_slot] = cfg_count;
            s_next.rem[cfg_slot]     = cfg_count;
            s_next.cfg_dly[cfg_slot] = cfg_delay;
        end

        // Fault latch and clearing
        unique case (s_reg.state)
            dfa_pkg::ST_NORMAL: begin
                if (first_hit != dfa_pkg::F_NONE) begin
                    s_next.code = first_hit;
                    if (power_only(first_hit) || !s_reg.fitted) begin
                        s_next.state = dfa_pkg::ST_LOCKED;
                    end else if (s_reg.rem[slot] != '0) begin
                        s_next.state     = dfa_pkg::ST_PENDING;
                        s_next.secs      = s_reg.cfg_dly[slot];
                        s_next.rem[slot] = s_reg.rem[slot] - dfa_pkg::CNT_W'(1);
                    end else begin
                        s_next.state = dfa_pkg::ST_HOLD;
                    end
                end
            end
            dfa_pkg::ST_HOLD: begin
                if (key_press) begin
                    s_next.state = dfa_pkg::ST_NORMAL;
                    s_next.code  = dfa_pkg::F_NONE;
                end
            end
            dfa_pkg::ST_PENDING: begin
                if (key_press) begin
                    s_next.state = dfa_pkg::ST_NORMAL;
                    s_next.code  = dfa_pkg::F_NONE;
                end else if (sec_tick) begin
                    if (s_reg.secs <= dfa_pkg::SEC_W'(1)) begin
                        s_next.state = dfa_pkg::ST_NORMAL;
                        s_next.code  = dfa_pkg::F_NONE;
                        s_next.secs  = '0;
                    end else begin
                        s_next.secs = s_reg.secs - dfa_pkg::SEC_W'(1);
                    end
                end
            end
            dfa_pkg::ST_LOCKED: begin
                s_next.state = dfa_pkg::ST_LOCKED;
            end
        endcase

        // Countdown digits for the bottom row
        d_hund = dfa_pkg::CHR_ZERO + (s_reg.secs / dfa_pkg::DEC_HUND);
        d_ten  = dfa_pkg::CHR_ZERO + ((s_reg.secs / dfa_pkg::DEC_TEN) % dfa_pkg::DEC_TEN);
        d_one  = dfa_pkg::CHR_ZERO + (s_reg.secs % dfa_pkg::DEC_TEN);

        // Character lookup for the display controller
        if (!disp_row) begin
            row_text = fault_text(s_reg.code);
        end else begin
            unique case (s_reg.state)
                dfa_pkg::ST_PENDING: row_text = {"RESTART IN ", d_hund, d_ten,
                                                 d_one, " S"};
                dfa_pkg::ST_HOLD:    row_text = "PRESS OFF KEY   ";
                dfa_pkg::ST_LOCKED:  row_text = "CYCLE POWER     ";
                default:             row_text = "                ";
            endcase
        end
        if (!s_reg.fitted || (disp_col >= dfa_pkg::COL_W'(dfa_pkg::MSG_CHARS))) begin
            s_next.chr = dfa_pkg::CHR_SPACE;
        end else begin
            s_next.chr = pick_char(row_text, disp_col[3:0]);
        end
    end

    // State register; reset stands for input power returning
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= RESET_S;
        end else begin
            s_reg <= s_next;
        end
    end

    // Lamp drivers
    dfa_lamp_if green_if ();
    dfa_lamp_if yellow_if ();
    dfa_lamp_if red_if ();

    assign pattern          = lamp_pattern(s_reg.code);
    assign green_if.mode    = dfa_pkg::dfa_lamp_e'(pattern[5:4]);
    assign yellow_if.mode   = dfa_pkg::dfa_lamp_e'(pattern[3:2]);
    assign red_if.mode      = dfa_pkg::dfa_lamp_e'(pattern[1:0]);
    assign green_if.phase   = s_reg.flash;
    assign yellow_if.phase  = s_reg.flash;
    assign red_if.phase     = s_reg.flash;

    dfa_lamp u_green (
        .clock  (clock),
        .arst_n (arst_n),
        .lp     (green_if)
    );

    dfa_lamp u_yellow (
        .clock  (clock),
        .arst_n (arst_n),
        .lp     (yellow_if)
    );

    dfa_lamp u_red (
        .clock  (clock),
        .arst_n (arst_n),
        .lp     (red_if)
    );

    // Outputs
    assign lamp_green      = green_if.lit;
    assign lamp_yellow     = yellow_if.lit;
    assign lamp_red        = red_if.lit;
    assign disp_char       = s_reg.chr;
    assign drive_run       = (s_reg.state == dfa_pkg::ST_NORMAL);
    assign restart_pending = (s_reg.state == dfa_pkg::ST_PENDING);
    assign fault_code      = s_reg.code;
    assign keypad_fitted   = s_reg.fitted;
endmodule : dfa_top
`default_nettype wire

// ===== shared/dfa_pkg.sv
// Shared constants and types for the drive fault annunciator
`default_nettype none
package dfa_pkg;
    // Timebase: 125 MHz clock, lamp flash toggles every half second
    localparam int CLK_MHZ      = 125;
    localparam int HALF_SEC_MS  = 500;
    localparam int HALF_SEC_CYC = HALF_SEC_MS * CLK_MHZ * 1000;
    localparam int TICK_W       = 27;

    // Fault and restart bookkeeping widths
    localparam int NUM_FAULTS   = 9;
    localparam int NUM_AUTO     = 4;
    localparam int SLOT_W       = 2;
    localparam int CNT_W        = 4;
    localparam int SEC_W        = 8;

    // Display geometry: two rows of 32 characters, messages use the left 16
    localparam int ROW_CHARS    = 32;
    localparam int COL_W        = 5;
    localparam int MSG_CHARS    = 16;
    localparam logic [7:0] CHR_SPACE = 8'h20;
    localparam logic [7:0] CHR_ZERO  = 8'h30;
    localparam logic [7:0] DEC_HUND  = 8'h64;
    localparam logic [7:0] DEC_TEN   = 8'h0A;

    // Strap capture: sample after the synchroniser has filled
    localparam logic [1:0] STRAP_TAKE = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    // Latched fault identity, F_NONE means healthy
    typedef enum logic [3:0] {
        F_OUTPUT_SHORT,
        F_OVER_TEMP,
        F_BUS_OVERVOLT,
        F_UNDER_CURRENT,
        F_SINGLE_PHASING,
        F_INTERNAL_SHORT,
        F_LOW_INPUT_VOLT,
        F_OVERCURRENT_OUT,
        F_DEFECTIVE_FAN,
        F_NONE
    } dfa_fault_e;

    // Lamp drive mode
    typedef enum logic [1:0] {
        LAMP_OFF,
        LAMP_ON,
        LAMP_FLASH
    } dfa_lamp_e;

    // Annunciator control states
    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_HOLD,
        ST_PENDING,
        ST_LOCKED
    } dfa_state_e;
endpackage : dfa_pkg
`default_nettype wire

// ===== shared/dfa_lamp_if.sv
// Link between the annunciator core and one lamp driver
`default_nettype none
interface dfa_lamp_if;
    dfa_pkg::dfa_lamp_e mode;
    logic               phase;
    logic               lit;

    modport drv (input mode, input phase, output lit);
    modport ctl (output mode, output phase, input lit);
endinterface : dfa_lamp_if
`default_nettype wire

// ===== src/dfa_lamp.sv
// One status lamp driver: off, steady or flashing
`default_nettype none
module dfa_lamp (
    input  wire logic clock,
    input  wire logic arst_n,
    dfa_lamp_if.drv   lp
);
    typedef struct packed {
        logic lit;
    } dfa_lamp_s;

    dfa_lamp_s s_reg;
    dfa_lamp_s s_next;

    // Steady modes ignore the phase, flash follows it
    always_comb begin
        s_next     = s_reg;
        s_next.lit = (lp.mode == dfa_pkg::LAMP_ON) ||
                     ((lp.mode == dfa_pkg::LAMP_FLASH) && lp.phase);
    end

    // Lamp dark during reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign lp.lit = s_reg.lit;
endmodule : dfa_lamp
`default_nettype wire

// ===== tb/dfa_checker.sv
// Port-level concurrent checks for the drive fault annunciator
`default_nettype none
module dfa_checker #(
    parameter int HALF_SEC_CYCLES = 4
) (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic [8:0] fault_hit,
    input wire logic       keypad_strap,
    input wire logic       off_key,
    input wire logic       cfg_wr,
    input wire logic [1:0] cfg_slot,
    input wire logic [3:0] cfg_count,
    input wire logic [7:0] cfg_delay,
    input wire logic       disp_row,
    input wire logic [4:0] disp_col,
    input wire logic [7:0] disp_char,
    input wire logic       lamp_green,
    input wire logic       lamp_yellow,
    input wire logic       lamp_red,
    input wire logic       drive_run,
    input wire logic       restart_pending,
    input wire logic [3:0] fault_code,
    input wire logic       keypad_fitted
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Lamp patterns follow the latched fault one edge later
    a_healthy_green: assert property (fault_code == 4'h9 |=>
        lamp_green && !lamp_yellow && !lamp_red) else $error("healthy lamps wrong");
    a_short_flash: assert property (fault_code == 4'h0 |=>
        lamp_green == lamp_red && !lamp_yellow) else $error("output short lamps wrong");
    a_temp_yellow: assert property (fault_code == 4'h1 |=>
        lamp_yellow && !lamp_green && !lamp_red) else $error("over temp lamps wrong");
    a_phase_steady: assert property (fault_code == 4'h4 |=>
        lamp_green && lamp_yellow && !lamp_red) else $error("single phase lamps wrong");
    a_overcur_all: assert property (fault_code == 4'h7 |=>
        lamp_green == lamp_yellow && lamp_yellow == lamp_red) else $error("flash out of phase");
    a_fan_red: assert property (fault_code == 4'h8 |=>
        lamp_red && !lamp_green && !lamp_yellow) else $error("fan lamps wrong");

    // Clearing and restart control
    a_run_only_healthy: assert property (drive_run |->
        fault_code == 4'h9 && !restart_pending) else $error("running with fault");
    a_locked_hold: assert property (fault_code inside {4'h0, 4'h2, 4'h4, 4'h5, 4'h8} |=>
        $stable(fault_code) && !drive_run && !restart_pending) else $error("lock left");
    a_no_keypad_lock: assert property (!keypad_fitted && fault_code != 4'h9 |=>
        $stable(fault_code) && !restart_pending) else $error("self restart");

    // Display text
    a_pending_shows: assert property (restart_pending && disp_row && disp_col == 5'h00 |=>
        disp_char == 8'h52) else $error("restart notice missing");
    a_blank_display: assert property (!keypad_fitted |=>
        disp_char == 8'h20) else $error("text without keypad");
endmodule : dfa_checker
`default_nettype wire

// ===== tb/dfa_partner.sv
// Fault detectors and keypad key that hold their levels a few cycles per request
`default_nettype none
module dfa_partner (
    input  wire logic       clock,
    input  wire logic       fault_req,
    input  wire logic [3:0] fault_idx,
    input  wire logic       key_req,
    output logic      [8:0] fault_hit,
    output logic            off_key
);
    timeunit 1ns;
    timeprecision 1ps;
    int         fault_left = 0;
    int         key_left = 0;
    logic [3:0] hit_idx = 4'h0;
    logic       take_fault;
    logic       take_key;

    // Requests taken at the edge; levels move just after it and last four cycles
    // Lines are quiet from the first edge on, while the block is still in reset
    always @(posedge clock) begin
        take_fault = fault_req;
        take_key = key_req;
        #1;
        if (take_fault) begin
            fault_left = 4;
            hit_idx = fault_idx;
        end
        if (take_key) key_left = 4;
        fault_hit = 9'h000;
        if (fault_left > 0) fault_hit[hit_idx] = 1'b1;
        off_key = key_left > 0;
        if (fault_left > 0) fault_left--;
        if (key_left > 0) key_left--;
    end
endmodule : dfa_partner
`default_nettype wire

// ===== tb/dfa_top_tb.sv
// Self-checking bench for the drive fault annunciator
`default_nettype none
module dfa_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock, arst_n, keypad_strap, off_key, cfg_wr, disp_row, fault_req, key_req;
    logic       lamp_green, lamp_yellow, lamp_red, drive_run, restart_pending, keypad_fitted;
    logic [8:0] fault_hit;
    logic [1:0] cfg_slot;
    logic [3:0] cfg_count, fault_code, fault_idx;
    logic [7:0] cfg_delay, disp_char;
    logic [4:0] disp_col;
    int         failures = 0;
    int         checked = 0;
    // Expected {green, yellow, red} modes per fault code: 0 off, 1 on, 2 flash
    localparam logic [5:0] PATTERN [9] = '{6'h22, 6'h04, 6'h28, 6'h08, 6'h14, 6'h12, 6'h06,
                                           6'h2A, 6'h01};

    dfa_top #(.HALF_SEC_CYCLES(4)) dfa_top_inst (.clock(clock), .arst_n(arst_n),
        .fault_hit(fault_hit), .keypad_strap(keypad_strap), .off_key(off_key), .cfg_wr(cfg_wr),
        .cfg_slot(cfg_slot), .cfg_count(cfg_count), .cfg_delay(cfg_delay), .disp_row(disp_row),
        .disp_col(disp_col), .disp_char(disp_char), .lamp_green(lamp_green),
        .lamp_yellow(lamp_yellow), .lamp_red(lamp_red), .drive_run(drive_run),
        .restart_pending(restart_pending), .fault_code(fault_code),
        .keypad_fitted(keypad_fitted));
    dfa_partner dfa_partner_inst (.clock(clock), .fault_req(fault_req), .fault_idx(fault_idx),
        .key_req(key_req), .fault_hit(fault_hit), .off_key(off_key));

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // Power cycle: reset held two cycles, then settle past strap capture
    task power_up(input logic strap);
        arst_n = 1'b0;
        keypad_strap = strap;
        step(2);
        arst_n = 1'b1;
        step(5);
        chk(8'(fault_code), 8'h09, "fault after power");
        chk(8'({lamp_green, lamp_yellow, lamp_red}), 8'h04, "healthy lamps");
        chk(8'(keypad_fitted), 8'(strap), "strap");
    endtask : power_up

    task raise(input logic [3:0] idx);
        fault_req = 1'b1;
        fault_idx = idx;
        step(1);
        fault_req = 1'b0;
        step(6);
    endtask : raise

    task press();
        key_req = 1'b1;
        step(1);
        key_req = 1'b0;
        step(8);
    endtask : press

    // Watch the lamps over three flash phases and classify each lamp
    task automatic observe(output logic [5:0] seen);
        logic [2:0] on_s = 3'h0;
        logic [2:0] off_s = 3'h0;
        repeat (12) begin
            step(1);
            on_s = on_s | {lamp_green, lamp_yellow, lamp_red};
            off_s = off_s | ~{lamp_green, lamp_yellow, lamp_red};
        end
        for (int k = 0; k < 3; k++) seen[2*k +: 2] = {on_s[k] & off_s[k], on_s[k] & ~off_s[k]};
    endtask : observe

    task automatic t_patterns();
        logic [5:0] seen;
        for (int i = 0; i < 9; i++) begin
            power_up(1'b0);
            raise(4'(i));
            raise(i == 0 ? 4'h8 : 4'h0);
            chk(8'(fault_code), 8'(i), "first fault kept");
            press();
            chk(8'(fault_code), 8'(i), "key without keypad");
            chk(8'(drive_run), 8'h00, "stopped");
            chk(disp_char, 8'h20, "blank text");
            observe(seen);
            chk(8'(seen), 8'(PATTERN[i]), "lamp pattern");
        end
        $display("test patterns done");
    endtask : t_patterns

    task t_keypad_clear();
        power_up(1'b1);
        disp_row = 1'b0;
        disp_col = 5'h00;
        step(1);
        chk(disp_char, 8'h53, "normal text");
        raise(4'h1);
        chk(8'(restart_pending), 8'h00, "no restarts by default");
        press();
        chk(8'(fault_code), 8'h09, "off key clears");
        chk(8'(drive_run), 8'h01, "running again");
        raise(4'h5);
        press();
        chk(8'(fault_code), 8'h05, "power only fault kept");
        chk(8'(drive_run), 8'h00, "still off");
        $display("test keypad clear done");
    endtask : t_keypad_clear

    task t_auto_restart();
        power_up(1'b1);
        cfg_slot = 2'h0;
        cfg_count = 4'h1;
        cfg_delay = 8'h02;
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
        raise(4'h1);
        chk(8'(restart_pending), 8'h01, "restart pending");
        disp_row = 1'b1;
        disp_col = 5'h00;
        step(1);
        chk(disp_char, 8'h52, "restart notice");
        disp_col = 5'h0D;
        step(1);
        chk(8'(disp_char inside {8'h31, 8'h32}), 8'h01, "countdown digit");
        for (int n = 0; n < 40 && drive_run !== 1'b1; n++) step(1);
        chk(8'(drive_run), 8'h01, "restart taken");
        raise(4'h1);
        chk(8'(restart_pending), 8'h00, "count used up");
        chk(8'(fault_code), 8'h01, "held fault");
        press();
        chk(8'(drive_run), 8'h01, "cleared from hold");
        cfg_slot = 2'h3;
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
        raise(4'h7);
        chk(8'(restart_pending), 8'h01, "overcurrent restart");
        $display("test auto restart done");
    endtask : t_auto_restart

    task tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Free-running 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Cut a hang short well past the expected run length
    initial begin
        #200us;
        failures++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {fault_req, key_req, cfg_wr, disp_row, arst_n, keypad_strap} = 6'h00;
        {fault_idx, cfg_slot, cfg_count, cfg_delay, disp_col} = 23'h000000;
        t_patterns();
        t_keypad_clear();
        t_auto_restart();
        tally_and_finish();
    end
endmodule : dfa_top_tb

bind dfa_top dfa_checker #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) dfa_checker_inst (.clock(clock),
    .arst_n(arst_n), .fault_hit(fault_hit), .keypad_strap(keypad_strap), .off_key(off_key),
    .cfg_wr(cfg_wr), .cfg_slot(cfg_slot), .cfg_count(cfg_count), .cfg_delay(cfg_delay),
    .disp_row(disp_row), .disp_col(disp_col), .disp_char(disp_char), .lamp_green(lamp_green),
    .lamp_yellow(lamp_yellow), .lamp_red(lamp_red), .drive_run(drive_run),
    .restart_pending(restart_pending), .fault_code(fault_code), .keypad_fitted(keypad_fitted));
`default_nettype wire
